// ==== hw/tbcp_fifo2.sv ====
// Purpose: Two-entry buffer between parser and transmit data FIFO
// Assumes: Same clock on both sides
// Notes: Read data come from a register
`timescale 1ns/1ns
`default_nettype none
module tbcp_fifo2 (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire tbcp_pkg::tbcp_word_t in_word,
    output logic out_valid,
    input wire logic out_ready,
    output tbcp_pkg::tbcp_word_t out_word
);
    tbcp_pkg::tbcp_word_t mem_r [2];
    logic wp_r;
    logic rp_r;
    logic [1:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Honest full and empty from the occupancy count
    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_word = mem_r[rp_r];

    // Storage and pointers
    always_ff @(posedge clk) begin
        if (rst) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                mem_r[wp_r] <= in_word;
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : tbcp_fifo2
`default_nettype wire

// ==== hw/tbcp_parser.sv ====
// Purpose: Transmit buffer command parser in front of the data FIFO
// Assumes: Host words arrive on the core clock with valid/ready
// Notes: Summary of operation follows
// Summary of operation
// - Each buffer: word A, word B, payload
// - Differing word B within packet flags error
// - Word B tag goes to status unchanged
// - Completion bit raises buffer loaded flag
// - Bits 25:24 select 4/16/32 byte end
// - Padding words are dropped
// - Start offset skips leading bytes
// - Bit 13 opens a new packet
// - Bit 12 closes current packet
// - Commands, offset, padding never stored
// - Summed sizes must match packet length
// - Offset low bits pick first lane
`timescale 1ns/1ns
`default_nettype none
module tbcp_parser (
    input wire logic CLK,
    input wire logic RST,
    input wire logic IN_VALID,
    output logic IN_READY,
    input wire logic [31:0] IN_DATA,
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output tbcp_pkg::tbcp_word_t OUT_WORD,
    output logic TRANSMIT_ERROR_FLAG,
    input wire logic ERR_CLR,
    output logic BUFFER_LOADED_FLAG,
    output logic STAT_VALID,
    output logic [15:0] STAT_TAG
);
    localparam int CW = tbcp_pkg::CNT_W;

    // Valid byte lanes of data word w for bytes in [off, off+size)
    function automatic logic [3:0] lane_mask(input logic [CW-1:0] w,
        input logic [4:0] off, input logic [10:0] size);
        logic [11:0] pos;
        logic [11:0] hi;
        logic [3:0] m;
        hi = {7'h00, off} + {1'b0, size};
        m = tbcp_pkg::BE_NONE;
        for (int j = 0; j < 4; j++) begin
            pos = {w, 2'b00} + 12'(j);
            m[j] = (pos >= {7'h00, off}) && (pos < hi);
        end
        return m;
    endfunction : lane_mask

    tbcp_pkg::tbcp_state_t state_r, state_nxt;
    logic [31:0] a_r;
    logic [31:0] b_r;
    logic in_pkt_r;
    logic [11:0] sum_r;
    logic [CW-1:0] wcnt_r;
    logic [CW-1:0] dwords_r;
    logic [CW-1:0] twords_r;
    logic err_r;
    logic loaded_r;
    logic stat_valid_r;
    logic [15:0] stat_tag_r;
    logic f_in_ready;

    // Fields of the held command word A
    wire [4:0] off = a_r[tbcp_pkg::A_OFF_HI:tbcp_pkg::A_OFF_LO];
    wire [10:0] size = a_r[tbcp_pkg::SIZE_HI:0];
    wire [1:0] align = a_r[tbcp_pkg::A_ALIGN_HI:tbcp_pkg::A_ALIGN_LO];
    wire fs = a_r[tbcp_pkg::A_FIRST];
    wire ls = a_r[tbcp_pkg::A_LAST];
    wire ioc = a_r[tbcp_pkg::A_IOC];

    // Data words and padded words of the buffer
    wire [CW-1:0] span = CW'(({7'h00, off} + {1'b0, size} + 12'h003) >> 2);
    wire [CW-1:0] aw = (align == tbcp_pkg::ALIGN_16) ? tbcp_pkg::WORDS_16 :
                       (align == tbcp_pkg::ALIGN_32) ? tbcp_pkg::WORDS_32 :
                       tbcp_pkg::WORDS_4;
    wire [CW-1:0] padded = (span + aw - CW'(1)) & ~(aw - CW'(1));

    // Handshake and word selection
    wire [3:0] be = lane_mask(wcnt_r, off, size);
    wire keep = (be != tbcp_pkg::BE_NONE);
    wire in_data = (state_r == tbcp_pkg::TBCP_DATA);
    assign IN_READY = !in_data || !keep || f_in_ready;
    wire acc = IN_VALID && IN_READY;
    wire acc_a = acc && (state_r == tbcp_pkg::TBCP_CMD_A);
    wire acc_b = acc && (state_r == tbcp_pkg::TBCP_CMD_B);
    wire acc_d = acc && in_data;
    wire push = acc_d && keep;
    wire last_word = (wcnt_r == twords_r - CW'(1));
    wire buf_end = (acc_d && last_word) || (acc_b && padded == '0);
    wire [11:0] sum_nxt = (fs ? 12'h000 : sum_r) + {1'b0, size};

    // Error causes seen when word B is taken
    wire b_diff = acc_b && !fs && (IN_DATA != b_r);
    wire len_bad = acc_b && ls &&
        (sum_nxt != {1'b0, IN_DATA[tbcp_pkg::SIZE_HI:0]});
    wire rsv_align = acc_b && (align == tbcp_pkg::ALIGN_RSV);
    wire orphan = acc_b && !fs && !in_pkt_r;
    wire err_set = b_diff || len_bad || rsv_align || orphan;
    wire [15:0] tag_src = acc_b ?
        IN_DATA[tbcp_pkg::B_TAG_HI:tbcp_pkg::B_TAG_LO] :
        b_r[tbcp_pkg::B_TAG_HI:tbcp_pkg::B_TAG_LO];

    tbcp_pkg::tbcp_word_t w_in;
    assign w_in.data = IN_DATA;
    assign w_in.be = be;
    assign w_in.last = ls && (wcnt_r == span - CW'(1));

    // Next state: A, then B, then data and padding words
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            tbcp_pkg::TBCP_CMD_A: begin
                if (acc) state_nxt = tbcp_pkg::TBCP_CMD_B;
            end
            tbcp_pkg::TBCP_CMD_B: begin
                if (acc) state_nxt = (padded == '0) ? tbcp_pkg::TBCP_CMD_A
                                                    : tbcp_pkg::TBCP_DATA;
            end
            tbcp_pkg::TBCP_DATA: begin
                if (acc && last_word) state_nxt = tbcp_pkg::TBCP_CMD_A;
            end
            default: state_nxt = tbcp_pkg::TBCP_CMD_A;
        endcase
    end

    // Command capture and word counting
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_r <= tbcp_pkg::TBCP_CMD_A;
            a_r <= 32'h0000_0000;
            b_r <= 32'h0000_0000;
            wcnt_r <= '0;
            dwords_r <= '0;
            twords_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (acc_a) a_r <= IN_DATA;
            if (acc_b) begin
                b_r <= IN_DATA;
                wcnt_r <= '0;
                dwords_r <= span;
                twords_r <= padded;
            end else if (acc_d) begin
                wcnt_r <= wcnt_r + CW'(1);
            end
        end
    end

    // Packet tracking and size accumulation
    always_ff @(posedge CLK) begin
        if (RST) begin
            in_pkt_r <= 1'b0;
            sum_r <= 12'h000;
        end else if (acc_b) begin
            sum_r <= sum_nxt;
            in_pkt_r <= !ls && (fs || in_pkt_r);
        end
    end

    // Sticky error, set wins over clear
    always_ff @(posedge CLK) begin
        if (RST) err_r <= 1'b0;
        else err_r <= err_set || (err_r && !ERR_CLR);
    end

    // Completion pulses and packet status
    always_ff @(posedge CLK) begin
        if (RST) begin
            loaded_r <= 1'b0;
            stat_valid_r <= 1'b0;
            stat_tag_r <= 16'h0000;
        end else begin
            loaded_r <= buf_end && ioc;
            stat_valid_r <= buf_end && ls;
            if (buf_end && ls) stat_tag_r <= tag_src;
        end
    end

    assign TRANSMIT_ERROR_FLAG = err_r;
    assign BUFFER_LOADED_FLAG = loaded_r;
    assign STAT_VALID = stat_valid_r;
    assign STAT_TAG = stat_tag_r;

    // Two-entry buffer absorbs a stall of the data FIFO
    tbcp_fifo2 u_buf (
        .clk(CLK),
        .rst(RST),
        .in_valid(push),
        .in_ready(f_in_ready),
        .in_word(w_in),
        .out_valid(OUT_VALID),
        .out_ready(OUT_READY),
        .out_word(OUT_WORD)
    );

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_err_on_bdiff: assert property (b_diff |=> TRANSMIT_ERROR_FLAG)
        else $error("word B mismatch did not set error");
    a_err_on_len: assert property (len_bad |=> TRANSMIT_ERROR_FLAG)
        else $error("length mismatch did not set error");
    a_err_on_rsv: assert property (rsv_align |=> TRANSMIT_ERROR_FLAG)
        else $error("reserved alignment did not set error");
    a_err_orphan: assert property (orphan |=> TRANSMIT_ERROR_FLAG)
        else $error("orphan buffer did not set error");
    a_loaded_cause: assert property (
        BUFFER_LOADED_FLAG |-> $past(buf_end) && $past(ioc))
        else $error("loaded flag without completed buffer");
    a_tag_kept: assert property (
        STAT_VALID |-> STAT_TAG == $past(tag_src))
        else $error("status tag differs from word B");
    a_no_pad_push: assert property (
        acc_d && wcnt_r >= dwords_r |-> !push)
        else $error("padding word pushed");
    a_first_lane: assert property (
        acc_d && wcnt_r == '0 && off < 5'h04 && size != '0
        |-> be[off[1:0]]
        && (be & ((4'h1 << off[1:0]) - 4'h1)) == tbcp_pkg::BE_NONE)
        else $error("first lane wrong");
    a_cmd_dropped: assert property (acc_a || acc_b |-> !push)
        else $error("command word pushed");
    // Only words with at least one payload lane ever leave the buffer
    a_out_lanes: assert property (
        OUT_VALID |-> OUT_WORD.be != tbcp_pkg::BE_NONE)
        else $error("empty word reached the output");
    a_pkt_open: assert property (acc_b && fs && !ls |=> in_pkt_r)
        else $error("first segment did not open packet");

    c_single: cover property (acc_b && fs && ls ##[1:40] STAT_VALID);
    c_multi: cover property (acc_b && fs && !ls ##[1:60] acc_b && ls);
    c_stall: cover property (IN_VALID && !IN_READY);
    c_err: cover property (err_set && ERR_CLR);
endmodule : tbcp_parser
`default_nettype wire

// ==== hw/tbcp_pkg.sv ====
// Purpose: Shared constants and types of the transmit command parser
// Assumes: One core clock, words written in host order
// Notes: Field positions of command words A and B
package tbcp_pkg;
    localparam int A_IOC = 31;
    localparam int A_ALIGN_HI = 25;
    localparam int A_ALIGN_LO = 24;
    localparam int A_OFF_HI = 20;
    localparam int A_OFF_LO = 16;
    localparam int A_FIRST = 13;
    localparam int A_LAST = 12;
    localparam int SIZE_HI = 10;
    localparam int B_TAG_HI = 31;
    localparam int B_TAG_LO = 16;
    localparam int CNT_W = 10;
    localparam logic [1:0] ALIGN_4 = 2'h0;
    localparam logic [1:0] ALIGN_16 = 2'h1;
    localparam logic [1:0] ALIGN_32 = 2'h2;
    localparam logic [1:0] ALIGN_RSV = 2'h3;
    localparam logic [CNT_W-1:0] WORDS_4 = 10'h001;
    localparam logic [CNT_W-1:0] WORDS_16 = 10'h004;
    localparam logic [CNT_W-1:0] WORDS_32 = 10'h008;
    localparam logic [3:0] BE_NONE = 4'h0;

    typedef enum logic [1:0] {
        TBCP_CMD_A = 2'b00,
        TBCP_CMD_B = 2'b01,
        TBCP_DATA = 2'b10
    } tbcp_state_t;

    // One word towards the data FIFO with its valid byte lanes
    typedef struct packed {
        logic [31:0] data;
        logic [3:0] be;
        logic last;
    } tbcp_word_t;
endpackage : tbcp_pkg

// ==== tb/tbcp_host.sv ====
// Purpose: Host model that writes transmit buffers word by word
// Assumes: Words change at the falling edge, hold until accepted
// Notes: A released data line shows the inverse of its last word
`timescale 1ns/1ns
`default_nettype none
module tbcp_host (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_ready,
    output logic in_valid,
    output logic [31:0] in_data
);
    logic [31:0] q[$];
    logic taken = 1'b0;
    initial begin
        in_valid = 1'b0;
        in_data = 32'h0;
    end
    // Note the word the parser took at this edge
    always @(posedge clk) begin
        taken <= in_valid && in_ready && !rst;
    end
    // Present the next word or release the line
    always @(negedge clk) begin
        if (taken) begin
            void'(q.pop_front());
        end
        if (q.size() > 0) begin
            in_valid = 1'b1;
            in_data = q[0];
        end else if (in_valid) begin
            in_valid = 1'b0;
            in_data = ~in_data;
        end
    end
    // Queue one buffer: word A, word B, then padded payload
    task automatic send_buf(input logic [31:0] a, input logic [31:0] b);
        int d;
        int unit;
        int n;
        d = (int'(a[20:16]) + int'(a[10:0]) + 3) / 4;
        unit = (a[25:24] == 2'h1) ? 4 : (a[25:24] == 2'h2) ? 8 : 1;
        n = (d + unit - 1) / unit * unit;
        q.push_back(a);
        q.push_back(b);
        for (int k = 0; k < n; k++) begin
            q.push_back({4{8'(8'h10 + k)}});
        end
    endtask : send_buf
endmodule : tbcp_host
`default_nettype wire

// ==== tb/tbcp_parser_tb.sv ====
// Purpose: Self-checking bench of the transmit command parser
// Assumes: Host model feeds words, bench drains the output side
// Notes: Output words are compared in order against a queue
`timescale 1ns/1ns
`default_nettype none
module tbcp_parser_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic in_valid, in_ready, out_valid, out_ready, err_clr;
    logic transmit_error_flag, loaded, stat_valid, saw_full;
    logic [31:0] in_data;
    logic [15:0] stat_tag, last_tag;
    tbcp_pkg::tbcp_word_t out_word;
    tbcp_pkg::tbcp_word_t exp_q[$];
    int err_count = 0;
    int cmp_count = 0;
    int load_cnt = 0;
    int stat_cnt = 0;
    always #25 clk = ~clk;
    tbcp_host u_host (
        .clk(clk), .rst(rst), .in_ready(in_ready),
        .in_valid(in_valid), .in_data(in_data)
    );
    tbcp_parser u_dut (
        .CLK(clk), .RST(rst), .IN_VALID(in_valid), .IN_READY(in_ready),
        .IN_DATA(in_data), .OUT_VALID(out_valid), .OUT_READY(out_ready),
        .OUT_WORD(out_word), .TRANSMIT_ERROR_FLAG(transmit_error_flag), .ERR_CLR(err_clr),
        .BUFFER_LOADED_FLAG(loaded), .STAT_VALID(stat_valid),
        .STAT_TAG(stat_tag)
    );
    // Compare one value and count the outcome
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Print counts and verdict, then stop
    task automatic test_done();
        $display("errors %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    // Build word A from its fields, reserved bits zero
    function automatic logic [31:0] mk_a(input logic ioc,
        input logic [1:0] al, input logic [4:0] off, input logic fs,
        input logic ls, input logic [10:0] size);
        return {ioc, 5'h00, al, 3'h0, off, 2'h0, fs, ls, 1'b0, size};
    endfunction : mk_a
    // Expect one kept payload word
    task automatic ex(input int k, input logic [3:0] be, input logic last);
        exp_q.push_back({{4{8'(8'h10 + k)}}, be, last});
    endtask : ex
    // Wait until host and output buffer are empty
    task automatic settle();
        int n;
        n = 0;
        while ((u_host.q.size() != 0 || in_valid || out_valid)
               && n < 300) begin
            @(negedge clk);
            n++;
        end
        // A stream that never drains counts as a mismatch
        if (n >= 300) err_count++;
        repeat (3) @(negedge clk);
    endtask : settle
    // Error must be set, then cleared by the clear input
    task automatic expect_err();
        settle();
        check(exp_q.size(), 0);
        check(transmit_error_flag, 1'b1);
        err_clr = 1'b1;
        @(negedge clk);
        err_clr = 1'b0;
        @(negedge clk);
        check(transmit_error_flag, 1'b0);
        exp_q.delete();
    endtask : expect_err
    // Watch output traffic and event pulses
    always @(posedge clk) begin
        if (!rst && loaded === 1'b1) load_cnt++;
        if (!rst && stat_valid === 1'b1) begin
            stat_cnt++;
            last_tag = stat_tag;
        end
        if (in_valid && in_ready === 1'b0) saw_full = 1'b1;
        if (out_valid === 1'b1 && out_ready && exp_q.size() > 0) begin
            check(out_word, exp_q.pop_front());
        end else if (out_valid === 1'b1 && out_ready && !transmit_error_flag) begin
            check(out_word, 37'h0);
        end
    end
    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        test_done();
    end
    // Main sequence
    initial begin
        out_ready = 1'b1;
        err_clr = 1'b0;
        saw_full = 1'b0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        check({in_ready, out_valid, transmit_error_flag, stat_tag}, {3'h4, 16'h0});
        // One-buffer packet, offset 5, 16-byte end
        u_host.send_buf(mk_a(1, 2'h1, 5'd5, 1, 1, 11'd6), 32'hbeef0006);
        ex(1, 4'he, 0);
        ex(2, 4'h7, 1);
        settle();
        check(exp_q.size(), 0);
        check(load_cnt, 1);
        check({stat_cnt, last_tag}, {32'd1, 16'hbeef});
        check(transmit_error_flag, 1'b0);
        // Two-buffer packet while the far side stalls
        out_ready = 1'b0;
        u_host.send_buf(mk_a(0, 2'h2, 5'd0, 1, 0, 11'd12), 32'h12340010);
        u_host.send_buf(mk_a(1, 2'h0, 5'd3, 0, 1, 11'd4), 32'h12340010);
        ex(0, 4'hf, 0);
        ex(1, 4'hf, 0);
        ex(2, 4'hf, 0);
        ex(0, 4'h8, 0);
        ex(1, 4'h7, 1);
        repeat (20) @(negedge clk);
        check({saw_full, out_valid}, 2'h3);
        out_ready = 1'b1;
        settle();
        check(exp_q.size(), 0);
        check({load_cnt, stat_cnt}, {32'd2, 32'd2});
        check({last_tag, transmit_error_flag}, {16'h1234, 1'b0});
        // Error cases, each cleared before the next
        u_host.send_buf(mk_a(0, 2'h3, 5'd0, 1, 1, 11'd4), 32'h4);
        expect_err();
        // Size 0 keeps the running sum and word B equal, so only the
        // missing open packet can raise the error
        u_host.send_buf(mk_a(0, 2'h0, 5'd0, 0, 1, 11'd0), 32'h4);
        expect_err();
        u_host.send_buf(mk_a(0, 2'h0, 5'd0, 1, 1, 11'd4), 32'h5);
        expect_err();
        ex(0, 4'hf, 0);
        u_host.send_buf(mk_a(0, 2'h0, 5'd0, 1, 0, 11'd4), 32'h00010008);
        u_host.send_buf(mk_a(0, 2'h0, 5'd0, 0, 1, 11'd4), 32'h00020008);
        expect_err();
        test_done();
    end
endmodule : tbcp_parser_tb
`default_nettype wire
